//--- wwdt_regs.svh
// Notes on behaviour
// - Window 10: early half clears interrupt
// - Window 11: early three quarters interrupt
// - Gear clock periods 2^18 to 2^24
// - Low clock periods 2^11 to 2^17
// - Action bit: interrupt or reset request
// - Fields locked while enable reads one
// - Enabling write also loads the fields
// - Config bit 7 reads 1, bit 6 0
// - Code 0x4E zeroes counter in window
// - Code 0xB1 stops only when enable 0
// - Other codes have no effect
// - Count view returns counter, read-only
// - Window 00: clear allowed any time
// - Disabled counter forced to zero
// - Early clear interrupts, counter keeps counting
// - Counter holds during stop, idle, sleep
`ifndef WWDT_REGS_SVH
`define WWDT_REGS_SVH

`define WWDT_IDX_CONFIG 16'h0fd4
`define WWDT_IDX_CODE 16'h0fd5
`define WWDT_IDX_COUNT 16'h0fd6
`define WWDT_IDX_EVENT 16'h0fd8
`define WWDT_IDX_MASK 16'h0fd9
`define WWDT_IDX_MODE 16'h0fda
`define WWDT_ADDR_SHIFT 2

`define WWDT_CFG_RESET 6'h26
`define WWDT_CFG_FIXED 2'b10
`define WWDT_CFG_EN_BIT 5
`define WWDT_MODE_DIV_BIT 0
`define WWDT_MODE_RUN_BIT 1

`define WWDT_CODE_CLEAR 8'h4e
`define WWDT_CODE_DISABLE 8'hb1

`define WWDT_WIN_ALWAYS 2'b00
`define WWDT_WIN_QUARTER 2'b01
`define WWDT_WIN_HALF 2'b10
`define WWDT_WIN_3Q 2'b11
`define WWDT_CNT_QUARTER 8'h40
`define WWDT_CNT_HALF 8'h80
`define WWDT_CNT_3Q 8'hc0
`define WWDT_CNT_MAX 8'hff

`define WWDT_GEAR_LOG2 18
`define WWDT_LOW_LOG2 11
`define WWDT_CNT_LOG2 8
`define WWDT_PRE_W 16

`endif

//--- wwdt_pkg.sv
package wwdt_pkg;

	typedef struct packed {
		logic enable;
		logic [1:0] window;
		logic [1:0] period;
		logic action;
	} wwdt_cfg_t;

	typedef struct packed {
		logic reset_req;
		logic early;
		logic overflow;
	} wwdt_evt_t;

	typedef enum logic [1:0] {
		WWDT_STOPPED = 2'b01,
		WWDT_RUNNING = 2'b10
	} wwdt_run_t;

endpackage : wwdt_pkg

//--- wwdt_prescaler.sv
`timescale 1ns/1ps
`include "wwdt_regs.svh"

module wwdt_prescaler (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic src_en,
	input wire logic clear,
	input wire logic [4:0] shift,
	output logic tick
);
	logic [`WWDT_PRE_W-1:0] pre_reg;
	logic [`WWDT_PRE_W-1:0] mask;

	// Mask of the low bits that must all be one before the counter steps.
	assign mask = ~({`WWDT_PRE_W{1'b1}} << shift);
	assign tick = src_en & ((pre_reg & mask) == mask);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_reg <= '0;
		end else if (clear) begin
			pre_reg <= '0;
		end else if (src_en) begin
			pre_reg <= pre_reg + 1'b1;
		end
	end

endmodule : wwdt_prescaler

//--- wwdt_top.sv
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "wwdt_regs.svh"

module wwdt_top #(
	parameter int GEAR_LOG2 = `WWDT_GEAR_LOG2,
	parameter int LOW_LOG2 = `WWDT_LOW_LOG2
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic low_frequency_clock,
	input wire logic slow_mode,
	input wire logic hold_count,
	output logic wdt_irq_req,
	output logic wdt_reset_req,
	output logic irq,
	output wwdt_pkg::wwdt_cfg_t cfg_out
);
	import wwdt_pkg::*;

	// ********************************************************
	// Address decode and clear window helpers
	// ********************************************************

	function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] idx);
		addr_hit = (addr == 16'(idx << `WWDT_ADDR_SHIFT));
	endfunction : addr_hit

	// Only mapped offsets answer without an error.
	function automatic logic addr_mapped(input logic [15:0] addr);
		addr_mapped = addr_hit(addr, `WWDT_IDX_CONFIG) |
			addr_hit(addr, `WWDT_IDX_CODE) |
			addr_hit(addr, `WWDT_IDX_COUNT) |
			addr_hit(addr, `WWDT_IDX_EVENT) |
			addr_hit(addr, `WWDT_IDX_MASK) |
			addr_hit(addr, `WWDT_IDX_MODE);
	endfunction : addr_mapped

	// A clear that lands before the window opens counts as a fault.
	function automatic logic clear_too_early(input logic [1:0] win, input logic [7:0] cnt);
		unique case (win)
			`WWDT_WIN_ALWAYS: clear_too_early = 1'b0;
			`WWDT_WIN_QUARTER: clear_too_early = (cnt < `WWDT_CNT_QUARTER);
			`WWDT_WIN_HALF: clear_too_early = (cnt < `WWDT_CNT_HALF);
			`WWDT_WIN_3Q: clear_too_early = (cnt < `WWDT_CNT_3Q);
		endcase
	endfunction : clear_too_early

	// ********************************************************
	// Declarations
	// ********************************************************

	wwdt_cfg_t cfg_reg;
	wwdt_run_t run_reg;
	wwdt_evt_t event_reg;
	wwdt_evt_t mask_reg;
	wwdt_evt_t evt_now;
	logic div_opt_reg;
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic [31:0] prdata_reg;
	logic [31:0] rdata_mux;
	logic wdt_irq_req_reg;
	logic wdt_reset_req_reg;
	logic lf_sync1_reg;
	logic lf_sync2_reg;
	logic lf_prev_reg;
	logic lf_rise;
	logic setup_phase;
	logic access_phase;
	logic bus_wr;
	logic cfg_wr;
	logic code_wr;
	logic event_wr;
	logic mask_wr;
	logic mode_wr;
	logic clear_cmd;
	logic disable_cmd;
	logic early_clear;
	logic good_clear;
	logic running;
	logic use_low;
	logic src_en;
	logic pre_clear;
	logic pre_tick;
	logic cnt_tick;
	logic overflow;
	logic [4:0] shift;
	logic [4:0] gear_base;
	logic [4:0] low_base;
	logic sel_config;
	logic sel_code;
	logic sel_count;
	logic sel_event;
	logic sel_mask;
	logic sel_mode;

	// ********************************************************
	// Register selects
	// ********************************************************

	// One decoder per register keeps the read and write paths in step.
	assign sel_config = addr_hit(paddr, `WWDT_IDX_CONFIG);
	assign sel_code = addr_hit(paddr, `WWDT_IDX_CODE);
	assign sel_count = addr_hit(paddr, `WWDT_IDX_COUNT);
	assign sel_event = addr_hit(paddr, `WWDT_IDX_EVENT);
	assign sel_mask = addr_hit(paddr, `WWDT_IDX_MASK);
	assign sel_mode = addr_hit(paddr, `WWDT_IDX_MODE);

	// ********************************************************
	// APB slave
	// ********************************************************

	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable;
	// Every access completes in its first access cycle.
	assign pready = 1'b1;
	// Unmapped offsets are flagged but otherwise ignored.
	assign pslverr = access_phase & ~addr_mapped(paddr);
	assign bus_wr = access_phase & pwrite;
	assign cfg_wr = bus_wr & sel_config;
	assign code_wr = bus_wr & sel_code;
	assign event_wr = bus_wr & sel_event;
	assign mask_wr = bus_wr & sel_mask;
	assign mode_wr = bus_wr & sel_mode;
	assign prdata = prdata_reg;

	always_comb begin
		rdata_mux = '0;
		if (sel_config) begin
			rdata_mux[7:0] = {`WWDT_CFG_FIXED, cfg_reg};
		end else if (sel_count) begin
			rdata_mux[7:0] = cnt_reg;
		end else if (sel_event) begin
			rdata_mux[$bits(wwdt_evt_t)-1:0] = event_reg;
		end else if (sel_mask) begin
			rdata_mux[$bits(wwdt_evt_t)-1:0] = mask_reg;
		end else if (sel_mode) begin
			rdata_mux[`WWDT_MODE_DIV_BIT] = div_opt_reg;
			rdata_mux[`WWDT_MODE_RUN_BIT] = running;
		end
	end

	// Read data is captured in the setup cycle so it comes from a flip-flop.
	// The code port reads as zero; it is write-only.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_reg <= '0;
		end else if (setup_phase & ~pwrite) begin
			prdata_reg <= rdata_mux;
		end
	end

	// ********************************************************
	// Configuration register
	// ********************************************************

	// While enabled only the enable bit takes a write, so a stray store cannot shorten the period.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= `WWDT_CFG_RESET;
		end else if (cfg_wr) begin
			if (cfg_reg.enable) begin
				cfg_reg.enable <= pwdata[`WWDT_CFG_EN_BIT];
			end else begin
				cfg_reg <= pwdata[`WWDT_CFG_EN_BIT:0];
			end
		end
	end

	assign cfg_out = cfg_reg;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_opt_reg <= 1'b0;
		end else if (mode_wr) begin
			div_opt_reg <= pwdata[`WWDT_MODE_DIV_BIT];
		end
	end

	// ********************************************************
	// Control codes
	// ********************************************************

	// Anything but the two codes decodes to neither command.
	assign clear_cmd = code_wr & (pwdata[7:0] == `WWDT_CODE_CLEAR);
	// Stopping needs enable already cleared by software first.
	assign disable_cmd = code_wr & (pwdata[7:0] == `WWDT_CODE_DISABLE) &
		~cfg_reg.enable;
	assign early_clear = clear_cmd & running & clear_too_early(cfg_reg.window, cnt_reg);
	assign good_clear = clear_cmd & running & ~early_clear;

	// ********************************************************
	// Run state
	// ********************************************************

	// Clearing enable alone keeps the watchdog running; the disable code must follow.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_reg <= WWDT_RUNNING;
		end else begin
			unique case (run_reg)
				WWDT_RUNNING: begin
					if (disable_cmd) begin
						run_reg <= WWDT_STOPPED;
					end
				end
				WWDT_STOPPED: begin
					if (cfg_wr & pwdata[`WWDT_CFG_EN_BIT]) begin
						run_reg <= WWDT_RUNNING;
					end
				end
				default: begin
					run_reg <= WWDT_STOPPED;
				end
			endcase
		end
	end

	assign running = (run_reg == WWDT_RUNNING);

	// ********************************************************
	// Source clock selection
	// ********************************************************

	// The low-frequency pin is asynchronous, so only its second stage is used.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lf_sync1_reg <= 1'b0;
			lf_sync2_reg <= 1'b0;
			lf_prev_reg <= 1'b0;
		end else begin
			lf_sync1_reg <= low_frequency_clock;
			lf_sync2_reg <= lf_sync1_reg;
			lf_prev_reg <= lf_sync2_reg;
		end
	end

	assign lf_rise = lf_sync2_reg & ~lf_prev_reg;
	// The divider option and slow mode both move the count onto the low clock.
	assign use_low = slow_mode | div_opt_reg;
	assign gear_base = 5'(GEAR_LOG2 - `WWDT_CNT_LOG2);
	assign low_base = 5'(LOW_LOG2 - `WWDT_CNT_LOG2);
	// Each period step is four times the previous one.
	assign shift = (use_low ? low_base : gear_base) +
		{2'b00, cfg_reg.period, 1'b0};
	// Counting pauses in low-power modes; nothing is lost across them.
	assign src_en = (use_low ? lf_rise : 1'b1) & running & ~hold_count;
	// Restarting the prescaler makes each period after a clear exact.
	assign pre_clear = ~running | good_clear | disable_cmd;

	wwdt_prescaler u_prescaler (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.src_en(src_en),
		.clear(pre_clear),
		.shift(shift),
		.tick(pre_tick)
	);

	// ********************************************************
	// Up counter
	// ********************************************************

	// The tick is gated again so a stopped or held counter never steps.
	assign cnt_tick = pre_tick & running & ~hold_count;
	// Disable takes priority over a coinciding overflow, as does a valid clear.
	assign overflow = cnt_tick & (cnt_reg == `WWDT_CNT_MAX) & ~disable_cmd & ~good_clear;

	always_comb begin
		cnt_next = cnt_reg;
		if (~running | disable_cmd) begin
			cnt_next = '0;
		end else if (good_clear) begin
			cnt_next = '0;
		end else if (cnt_tick) begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// ********************************************************
	// Requests and interrupt status
	// ********************************************************

	assign evt_now.overflow = overflow & ~cfg_reg.action;
	assign evt_now.reset_req = overflow & cfg_reg.action;
	assign evt_now.early = early_clear;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdt_irq_req_reg <= 1'b0;
		end else begin
			wdt_irq_req_reg <= evt_now.overflow | evt_now.early;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdt_reset_req_reg <= 1'b0;
		end else begin
			wdt_reset_req_reg <= evt_now.reset_req;
		end
	end

	assign wdt_irq_req = wdt_irq_req_reg;
	assign wdt_reset_req = wdt_reset_req_reg;

	// A new event in the cycle of its clearing write stays set.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			event_reg <= '0;
		end else if (event_wr) begin
			event_reg <= (event_reg & ~wwdt_evt_t'(pwdata[$bits(wwdt_evt_t)-1:0])) | evt_now;
		end else begin
			event_reg <= event_reg | evt_now;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_reg <= '0;
		end else if (mask_wr) begin
			mask_reg <= pwdata[$bits(wwdt_evt_t)-1:0];
		end
	end

	// The line is a level, so software sees it until the status bit is cleared.
	assign irq = |(event_reg & mask_reg);

endmodule : wwdt_top

//--- wwdt_monitor.sv
`timescale 1ns/1ps
module wwdt_monitor #(
	parameter int GEAR_LOG2 = 18,
	parameter int LOW_LOG2 = 11
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic low_frequency_clock,
	input wire logic slow_mode,
	input wire logic hold_count,
	input wire logic wdt_irq_req,
	input wire logic wdt_reset_req,
	input wire logic irq,
	input wire wwdt_pkg::wwdt_cfg_t cfg_out
);
	import wwdt_pkg::*;
	// ****************************************
	// Bus-side and request-output relations of the watchdog.
	// ****************************************
	logic wr_cfg;
	logic rd_set;
	logic mapped;
	assign wr_cfg = psel && penable && pwrite && paddr == 16'h3f50;
	assign rd_set = psel && !penable && !pwrite;
	assign mapped = paddr inside {16'h3f50, 16'h3f54, 16'h3f58, 16'h3f60, 16'h3f64, 16'h3f68};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
		else $error("slave error does not match address map");
	a_cfg_lock: assert property (wr_cfg && cfg_out.enable |=> cfg_out[4:0] == $past(cfg_out[4:0]))
		else $error("config fields changed while enabled");
	a_cfg_load: assert property (wr_cfg && !cfg_out.enable |=> cfg_out == $past(pwdata[5:0]))
		else $error("config write not loaded");
	a_rst_pulse: assert property (wdt_reset_req |=> !wdt_reset_req [*8])
		else $error("reset request not a single pulse");
	a_rst_action: assert property (wdt_reset_req |-> $past(cfg_out.action))
		else $error("reset request with interrupt action");
	a_cfg_read: assert property (rd_set && paddr == 16'h3f50 |=> prdata == {24'h0, 2'b10, $past(cfg_out)})
		else $error("config read value wrong");
	a_cnt_upper: assert property (rd_set && paddr == 16'h3f58 |=> prdata[31:8] == 24'h0)
		else $error("count read upper bits set");
	a_hold_quiet: assert property (hold_count && $past(hold_count) |-> !wdt_reset_req)
		else $error("overflow while counting held");
endmodule : wwdt_monitor

bind wwdt_top wwdt_monitor #(.GEAR_LOG2(GEAR_LOG2), .LOW_LOG2(LOW_LOG2)) u_wwdt_monitor (
	.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.low_frequency_clock(low_frequency_clock), .slow_mode(slow_mode),
	.hold_count(hold_count), .wdt_irq_req(wdt_irq_req), .wdt_reset_req(wdt_reset_req),
	.irq(irq), .cfg_out(cfg_out));

//--- wwdt_top_tb.sv
`timescale 1ns/1ps
module wwdt_top_tb;
	import wwdt_pkg::*;
	// ****************************************
	// Stimulus and checks.
	// ****************************************
	localparam logic [15:0] CFG = 16'h3f50, CODE = 16'h3f54, CNT = 16'h3f58;
	localparam logic [15:0] EVT = 16'h3f60, MSK = 16'h3f64, MODE = 16'h3f68;
	localparam int GL2 = 9, LL2 = 8;
	logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic slow_mode = 0, hold_count = 0, pready, pslverr, wdt_irq_req, wdt_reset_req, irq, e;
	logic [15:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r, r2, x = 32'hd59a;
	logic [2:0] lc = 0;
	wire logic low_frequency_clock;
	wwdt_cfg_t cfg_out;
	int n_mismatch = 0, n_tests = 0, n_irq = 0, n_rst = 0, cyc = 0, k, t1, t2;
	// The low clock runs at one eighth of ref_clk, well inside the synchroniser's reach.
	assign low_frequency_clock = lc[2];
	wwdt_top #(.GEAR_LOG2(GL2), .LOW_LOG2(LL2)) u_wwdt_top (.ref_clk(ref_clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .slow_mode(slow_mode),
		.low_frequency_clock(low_frequency_clock), .hold_count(hold_count), .irq(irq),
		.wdt_irq_req(wdt_irq_req), .wdt_reset_req(wdt_reset_req), .cfg_out(cfg_out));
	initial forever #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		lc <= lc + 3'd1;
		cyc <= cyc + 1;
		n_irq <= n_irq + int'(wdt_irq_req === 1'b1);
		n_rst <= n_rst + int'(wdt_reset_req === 1'b1);
		if (cyc == 60000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	function automatic logic [31:0] xs();
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs
	function automatic logic [31:0] cfg_exp(input logic [5:0] v);
		return {24'h0, 2'b10, v};
	endfunction : cfg_exp
	function automatic int per_exp(input int log2, input int p);
		return 1 << (log2 + 2 * p);
	endfunction : per_exp
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic setcfg(input logic [5:0] v);
		apb(1, CFG, 0);
		apb(1, CODE, 32'hb1);
		apb(1, CFG, {26'h0, v});
		apb(0, CFG, 0);
		chk(r, cfg_exp(v), "cfg");
	endtask : setcfg
	task automatic wpulse(input bit rs, output int t);
		do @(posedge ref_clk); while ((rs ? wdt_reset_req : wdt_irq_req) !== 1'b1);
		t = cyc;
	endtask : wpulse
	task automatic give_verdict();
		$display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		apb(0, CFG, 0);
		chk(r, 32'ha6, "cfg reset");
		apb(0, CNT, 0);
		chk(r, 0, "cnt reset");
		apb(0, 16'h3f5c, 0);
		chk(e, 1, "unmapped err");
		chk(r, 0, "unmapped data");
		apb(1, CODE, 32'hb1);
		apb(0, MODE, 0);
		chk(r[1], 1, "b1 while enabled");
		apb(1, CFG, 32'h1f);
		apb(0, CFG, 0);
		chk(r, 32'h86, "locked fields");
		apb(1, CODE, 32'hb1);
		apb(0, MODE, 0);
		chk(r[1], 0, "stopped");
		repeat (300) @(posedge ref_clk);
		apb(0, CNT, 0);
		chk(r, 0, "stopped cnt");
		apb(1, CNT, 32'h55);
		apb(0, CNT, 0);
		chk(r, 0, "cnt read-only");
		setcfg(6'h20);
		repeat (100) @(posedge ref_clk);
		k = n_irq;
		repeat (6) begin
			r2 = xs();
			if (r2[7:0] == 8'h4e || r2[7:0] == 8'hb1) r2[0] = ~r2[0];
			apb(1, CODE, {24'h0, r2[7:0]});
		end
		apb(0, CNT, 0);
		chk(r[7:0] >= 8'h32, 1, "invalid code");
		chk(n_irq, k, "invalid irq");
		for (int w = 0; w < 4; w++) begin
			setcfg({1'b1, w[1:0], 3'b000});
			k = n_irq;
			repeat (90) @(posedge ref_clk);
			apb(1, CODE, 32'h4e);
			apb(0, CNT, 0);
			chk(r[7:0] < 8'h10, w == 0, "early clear");
			repeat (300) @(posedge ref_clk);
			apb(1, CODE, 32'h4e);
			apb(0, CNT, 0);
			chk(r[7:0] < 8'h10, 1, "late clear");
			chk(n_irq - k, w != 0, "early irq");
		end
		for (int p = 0; p < 3; p++) begin
			setcfg({3'b100, p[1:0], 1'b1});
			k = n_irq;
			wpulse(1, t1);
			wpulse(1, t2);
			chk(t2 - t1, per_exp(GL2, p), "gear period");
			chk(n_irq, k, "reset action");
		end
		for (int m = 0; m < 2; m++) begin
			slow_mode <= (m == 0);
			apb(1, MODE, m);
			setcfg(6'h21);
			wpulse(1, t1);
			wpulse(1, t2);
			chk(t2 - t1, per_exp(LL2 + 3, 0), "low period");
		end
		slow_mode <= 1'b0;
		apb(1, MODE, 0);
		setcfg(6'h21);
		repeat (100) @(posedge ref_clk);
		hold_count <= 1'b1;
		k = n_rst;
		apb(0, CNT, 0);
		r2 = r;
		repeat (600) @(posedge ref_clk);
		apb(0, CNT, 0);
		chk(r, r2, "hold cnt");
		chk(n_rst, k, "hold rst");
		hold_count <= 1'b0;
		repeat (20) @(posedge ref_clk);
		apb(0, CNT, 0);
		chk(r[7:0] > r2[7:0], 1, "resume");
		setcfg(6'h20);
		apb(0, EVT, 0);
		chk(r, 6, "event bits");
		apb(1, EVT, 7);
		apb(1, MSK, 0);
		wpulse(0, t1);
		repeat (2) @(posedge ref_clk);
		chk(irq, 0, "masked");
		apb(0, EVT, 0);
		chk(r[0], 1, "overflow event");
		apb(1, MSK, 1);
		@(negedge ref_clk);
		chk(irq, 1, "irq on");
		apb(1, EVT, 1);
		@(negedge ref_clk);
		chk(irq, 0, "irq cleared");
		apb(0, MSK, 0);
		chk(r, 1, "mask read");
		give_verdict();
	end
endmodule : wwdt_top_tb
